// ===== hw/sarc_regs.svh
// Register map, field positions, reset values and timing counts of the converter control.
// Included by the package and by the converter top; definitions only.
`ifndef SARC_REGS_SVH
`define SARC_REGS_SVH

// Printed offsets are word indices; byte address is four times the index
`define SARC_RESULT_IDX 8'hd0
`define SARC_CTRL_IDX 8'hd1
`define SARC_ADDR_W 12

// Control register fields
`define SARC_BIT_IRQ_EN 7
`define SARC_BIT_DONE 6
`define SARC_BIT_START 5
`define SARC_BIT_POWER 4
`define SARC_BIT_OSC_OFF 2
`define SARC_CTRL_RESET 8'h40

// Result register width and SAR seeds
`define SARC_RES_W 8
`define SARC_RES_MSB 8'h80
`define SARC_RES_ZERO 8'h00

// Nominal conversion time and core clock
`define SARC_CONV_TIME_NS 70000
`define SARC_CLK_PERIOD_NS 10
`define SARC_CONV_CYCLES (`SARC_CONV_TIME_NS / `SARC_CLK_PERIOD_NS)

`endif

// ===== hw/sarc_pkg.sv
// Types shared by the converter control design.
// Assumes sarc_regs.svh is reachable on the include path.
`include "sarc_regs.svh"

package sarc_pkg;

    // Conversion sequencer states, one-hot
    typedef enum logic [3:0] {
        SARC_ST_IDLE = 4'b0001,
        SARC_ST_CONV = 4'b0010,
        SARC_ST_LOAD = 4'b0100,
        SARC_ST_FLAG = 4'b1000
    } sarc_state_t;

    typedef logic [`SARC_RES_W-1:0] sarc_code_t;

endpackage : sarc_pkg

// ===== hw/sarc_sar_engine.sv
// Successive-approximation engine: trial code register and bit pointer.
// Assumes step pulses are spaced far enough apart for the comparator to settle
// and that i_keep is already synchronised to i_clk_sys.
`timescale 1ns/100ps

module sarc_sar_engine
    import sarc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_restart,
    input wire logic i_abort,
    input wire logic i_step,
    input wire logic i_keep,
    output sarc_code_t o_trial,
    output logic o_busy,
    output logic o_done
);

    sarc_code_t trial_q;
    sarc_code_t trial_d;
    sarc_code_t mask_q;
    sarc_code_t mask_d;
    logic busy_q;
    logic busy_d;
    logic done_q;
    logic done_d;
    sarc_code_t decided;
    logic last_bit;

    // Drop the bit under test when the input is below the trial level
    assign decided = i_keep ? trial_q : (trial_q & ~mask_q);
    assign last_bit = mask_q[0];

    // One bit per step, most significant first; restart beats abort and step
    always_comb
    begin
        trial_d = trial_q;
        mask_d = mask_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (i_restart)
        begin
            trial_d = `SARC_RES_MSB;
            mask_d = `SARC_RES_MSB;
            busy_d = 1'b1;
        end
        else if (i_abort)
        begin
            busy_d = 1'b0;
        end
        else if (busy_q && i_step)
        begin
            mask_d = mask_q >> 1;
            trial_d = decided | (mask_q >> 1);
            if (last_bit)
            begin
                trial_d = decided;
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            trial_q <= `SARC_RES_ZERO;
            mask_q <= `SARC_RES_ZERO;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            trial_q <= trial_d;
            mask_q <= mask_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign o_trial = trial_q;
    assign o_busy = busy_q;
    assign o_done = done_q;

endmodule : sarc_sar_engine

// ===== hw/sarc_adc_ctrl.sv
// Control logic of an 8-bit successive-approximation converter with an APB register slave.
// Assumes an external DAC takes o_dac_code and an external comparator reports on
// i_cmp_above whether the analog input is at or above the trial level.
//
// Overview of operation
// - Input at or above upper reference yields all-ones code, no overflow flag.
// - Input at or below lower reference yields all-zeros code.
// - Code never falls for a rising input, never rises for a falling one.
// - Writing one to start begins a conversion and clears the done flag.
// - Hardware sets done at conversion end; result valid only while done reads one.
// - Interrupt request raised when done is set and interrupt enable is one.
// - Start is watched always; a start mid-conversion abandons it and restarts.
// - Start bit is write-only and reads back as zero.
// - Writing zero to done does nothing; only a new start clears it.
// - Exactly one conversion per start, no automatic restart.
// - Power-select zero switches the converter off, one switches it on.
// - Wait mode leaves conversion running and irq wakes; stop mode disables converter.
// - Control register resets to done set, everything else clear.
// - Oscillator-off bit disables the main oscillator, not the converter.
// - A conversion takes about seventy microseconds nominal.
// - Eight-bit read-only result register sits one word below control; reset undefined.
`timescale 1ns/100ps
`include "sarc_regs.svh"

module sarc_adc_ctrl
    import sarc_pkg::*;
#(
    parameter int P_CONV_CYCLES = `SARC_CONV_CYCLES
)
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`SARC_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Analog front end
    input wire logic i_cmp_above,
    output logic [`SARC_RES_W-1:0] o_dac_code,
    output logic o_analog_on,
    // System
    input wire logic i_wait_mode,
    input wire logic i_stop_mode,
    output logic o_conv_irq,
    output logic o_wake_req,
    output logic o_main_osc_disable
);

    // Step spacing: the nominal time is shared by the eight bit decisions
    localparam int STEP_CYCLES = (P_CONV_CYCLES / `SARC_RES_W > 1) ?
                                 (P_CONV_CYCLES / `SARC_RES_W) : 2;
    localparam int CNT_W = $clog2(STEP_CYCLES + 1);
    localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);

    // Word address match for a printed register index
    function automatic logic addr_hit(input logic [`SARC_ADDR_W-1:0] addr,
                                      input logic [7:0] idx);
        addr_hit = (addr == `SARC_ADDR_W'({idx, 2'b00}));
    endfunction : addr_hit

    // Control register fields, stored bits only
    logic irq_en_q;
    logic done_q;
    logic done_d;
    logic power_q;
    logic osc_off_q;
    sarc_code_t result_q;
    sarc_state_t state_q;
    sarc_state_t state_d;

    // APB response registers
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // Comparator synchroniser, first stage read only by the second
    logic cmp_meta_q;
    logic cmp_sync_q;

    // Step divider
    logic [CNT_W-1:0] step_cnt_q;
    logic step_tick_q;

    // Registered side outputs
    logic analog_on_q;
    logic irq_q;
    logic wake_q;

    // Engine ports
    sarc_code_t eng_trial;
    logic eng_busy;
    logic eng_done;

    // Bus decode
    wire access_ph = i_psel && i_penable;
    wire answer_ph = access_ph && !pready_q;
    wire commit = access_ph && pready_q;
    wire hit_ctrl = addr_hit(i_paddr, `SARC_CTRL_IDX);
    wire hit_res = addr_hit(i_paddr, `SARC_RESULT_IDX);
    wire hit_any = hit_ctrl || hit_res;
    wire wr_ctrl = commit && i_pwrite && hit_ctrl;
    wire start_req = wr_ctrl && i_pwdata[`SARC_BIT_START];

    // Converter may run only when powered and not stopped
    wire conv_enabled = power_q && !i_stop_mode;
    wire abort_conv = !conv_enabled;
    wire eng_restart = start_req && conv_enabled;

    // Readback: start and reserved bits always zero, done read-only
    wire [7:0] ctrl_rd = {irq_en_q, done_q, 1'b0, power_q,
                          1'b0, osc_off_q, 2'b00};
    wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
                         hit_res ? {24'h000000, result_q} : 32'h00000000;

    // APB answer: one wait state so that every bus output comes from a flop
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= answer_ph;
            prdata_q <= (answer_ph && !i_pwrite) ? rd_mux : 32'h00000000;
            pslverr_q <= answer_ph && !hit_any;
        end
    end

    // Software-written control bits; writes to reserved bits are dropped
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            irq_en_q <= 1'b0;
            power_q <= 1'b0;
            osc_off_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            irq_en_q <= i_pwdata[`SARC_BIT_IRQ_EN];
            power_q <= i_pwdata[`SARC_BIT_POWER];
            osc_off_q <= i_pwdata[`SARC_BIT_OSC_OFF];
        end
    end

    // Done flag: set only by the sequencer, cleared only by a start write.
    // A start in the very cycle of completion wins, since it abandons that result.
    always_comb
    begin
        done_d = done_q;
        if (state_q == SARC_ST_FLAG)
        begin
            done_d = 1'b1;
        end
        if (start_req)
        begin
            done_d = 1'b0;
        end
    end

    // Sequencer: restart on a start while powered and not stopped, one conversion only, abort when unpowered or stopped
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            SARC_ST_IDLE:
            begin
                state_d = SARC_ST_IDLE;
            end
            SARC_ST_CONV:
            begin
                if (abort_conv)
                begin
                    state_d = SARC_ST_IDLE;
                end
                else if (eng_done)
                begin
                    state_d = SARC_ST_LOAD;
                end
            end
            SARC_ST_LOAD:
            begin
                state_d = SARC_ST_FLAG;
            end
            SARC_ST_FLAG:
            begin
                state_d = SARC_ST_IDLE;
            end
            default:
            begin
                state_d = SARC_ST_IDLE;
            end
        endcase
        if (eng_restart)
        begin
            state_d = SARC_ST_CONV;
        end
        else if (start_req)
        begin
            state_d = SARC_ST_IDLE;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            state_q <= SARC_ST_IDLE;
            done_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            done_q <= done_d;
        end
    end

    // Result captured two cycles before the done flag rises; no reset, content undefined
    always_ff @(posedge i_clk_sys)
    begin
        if (state_q == SARC_ST_CONV && eng_done && !abort_conv && !start_req)
        begin
            result_q <= eng_trial;
        end
    end

    // Comparator comes from the analog domain, so it is synchronised first
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end
        else
        begin
            cmp_meta_q <= i_cmp_above;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // Step divider, realigned on each start so every bit gets a full settle time
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst || eng_restart || !eng_busy)
        begin
            step_cnt_q <= '0;
            step_tick_q <= 1'b0;
        end
        else if (step_cnt_q == STEP_LAST)
        begin
            step_cnt_q <= '0;
            step_tick_q <= 1'b1;
        end
        else
        begin
            step_cnt_q <= step_cnt_q + CNT_W'(1);
            step_tick_q <= 1'b0;
        end
    end

    sarc_sar_engine u_engine (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_restart(eng_restart),
        .i_abort(abort_conv || (start_req && !conv_enabled)),
        .i_step(step_tick_q),
        .i_keep(cmp_sync_q),
        .o_trial(eng_trial),
        .o_busy(eng_busy),
        .o_done(eng_done)
    );

    // Side outputs; irq is a level that stays while done and enable are both set
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            analog_on_q <= 1'b0;
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else
        begin
            analog_on_q <= conv_enabled;
            irq_q <= done_d && irq_en_q;
            wake_q <= done_d && irq_en_q && i_wait_mode && !i_stop_mode;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_dac_code = eng_trial;
    assign o_analog_on = analog_on_q;
    assign o_conv_irq = irq_q;
    assign o_wake_req = wake_q;
    assign o_main_osc_disable = osc_off_q;

endmodule : sarc_adc_ctrl

// ===== tb/sarc_analog_model.sv
// Far side of the converter: one analog input level and a comparator.
// Assumes the level is held in code units, 300 standing for above the upper reference.
`timescale 1ns/100ps

module sarc_analog_model
(
    input wire logic i_clk_sys,
    input wire logic i_analog_on,
    input wire logic [7:0] i_dac_code,
    input wire logic [8:0] i_vin,
    input wire logic i_slow,
    output logic o_cmp_above
);
    logic cmp_now;
    logic late_q = 1'b0;
    logic junk_q = 1'b0;

    // One input pin only, so no two levels can short
    assign cmp_now = ({1'b0, i_dac_code} <= i_vin);
    // Unpowered comparator gives garbage, never a stale answer
    assign o_cmp_above = !i_analog_on ? junk_q : (i_slow ? late_q : cmp_now);

    // Slow mode answers one clock late
    always_ff @(posedge i_clk_sys)
    begin
        late_q <= cmp_now;
        junk_q <= ~junk_q;
    end
endmodule : sarc_analog_model

// ===== tb/sarc_adc_ctrl_properties.sv
// Port-level assertions of the converter control.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/100ps
`include "sarc_regs.svh"

module sarc_adc_ctrl_properties
#(
    parameter int P_CONV_CYCLES = 64
)
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`SARC_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_cmp_above,
    input wire logic [`SARC_RES_W-1:0] o_dac_code,
    input wire logic o_analog_on,
    input wire logic i_wait_mode,
    input wire logic i_stop_mode,
    input wire logic o_conv_irq,
    input wire logic o_wake_req,
    input wire logic o_main_osc_disable
);
    localparam logic [11:0] A_CTRL = {2'b00, `SARC_CTRL_IDX, 2'b00};
    localparam logic [11:0] A_RES = {2'b00, `SARC_RESULT_IDX, 2'b00};
    int since_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_ctrl_wr;
        i_psel && i_penable && o_pready && i_pwrite && i_paddr == A_CTRL;
    endsequence

    // Cycles since the last start; saturates so enabling later counts as old
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            since_q <= P_CONV_CYCLES;
        else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == A_CTRL
                 && i_pwdata[5])
            since_q <= 0;
        else if (since_q < P_CONV_CYCLES)
            since_q <= since_q + 1;
    end

    property p_rdy_two;
        s_setup |-> ##2 o_pready;
    endproperty
    a_rdy_two: assert property (p_rdy_two) else $error("pready late or early");
    property p_rdy_pulse;
        o_pready |=> !o_pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready over one cycle");
    property p_unmapped;
        s_setup ##0 (i_paddr != A_CTRL && i_paddr != A_RES) |-> ##2 (o_pslverr && o_prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_start_clr;
        s_ctrl_wr ##0 i_pwdata[5] |-> ##2 !o_conv_irq;
    endproperty
    a_start_clr: assert property (p_start_clr) else $error("start kept irq");
    property p_irq_en;
        s_ctrl_wr ##0 !i_pwdata[7] |-> ##2 !o_conv_irq;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
    property p_irq_hold;
        o_conv_irq && !(i_psel && i_penable && o_pready && i_pwrite)
            && !$past(i_psel && i_penable && o_pready && i_pwrite) |=> o_conv_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("done dropped");
    property p_no_auto;
        $rose(o_conv_irq) |-> since_q >= P_CONV_CYCLES - 8;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("done without start");
    property p_osc;
        s_ctrl_wr |=> o_main_osc_disable == $past(i_pwdata[2]);
    endproperty
    a_osc: assert property (p_osc) else $error("osc pin wrong");
    property p_pwr_off;
        s_ctrl_wr ##0 !i_pwdata[4] |-> ##2 !o_analog_on;
    endproperty
    a_pwr_off: assert property (p_pwr_off) else $error("analog on after off");
    property p_stop;
        i_stop_mode |=> !o_analog_on;
    endproperty
    a_stop: assert property (p_stop) else $error("analog on in stop");
    property p_wake;
        o_wake_req |-> o_conv_irq && $past(i_wait_mode);
    endproperty
    a_wake: assert property (p_wake) else $error("wake without cause");
endmodule : sarc_adc_ctrl_properties

bind sarc_adc_ctrl sarc_adc_ctrl_properties #(.P_CONV_CYCLES(P_CONV_CYCLES)) u_props (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_cmp_above(i_cmp_above),
    .o_dac_code(o_dac_code), .o_analog_on(o_analog_on), .i_wait_mode(i_wait_mode),
    .i_stop_mode(i_stop_mode), .o_conv_irq(o_conv_irq), .o_wake_req(o_wake_req),
    .o_main_osc_disable(o_main_osc_disable));

// ===== tb/sarc_adc_ctrl_tb.sv
// Self-checking bench of the converter control, register level over APB.
// Assumes the analog model on the comparator side; short conversion count.
`timescale 1ns/100ps
`include "sarc_regs.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module sarc_adc_ctrl_tb;
    localparam logic [11:0] AC = {2'b00, `SARC_CTRL_IDX, 2'b00};
    localparam logic [11:0] AR = {2'b00, `SARC_RESULT_IDX, 2'b00};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, err, cmp, aon, wt = 1'b0, stp = 1'b0;
    logic irq, wake, osc, slow = 1'b0, rdy, slv;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rdat;
    logic [7:0] dac;
    logic [8:0] vin = 9'h000;
    logic [8:0] vtab [5] = '{9'h000, 9'h12c, 9'h05a, 9'h0a5, 9'h001};
    logic [7:0] etab [5] = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h01};
    int fails = 0;
    int checks = 0;

    sarc_adc_ctrl #(.P_CONV_CYCLES(64)) dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
        .o_pready(rdy), .o_pslverr(slv), .i_cmp_above(cmp), .o_dac_code(dac),
        .o_analog_on(aon), .i_wait_mode(wt), .i_stop_mode(stp), .o_conv_irq(irq),
        .o_wake_req(wake), .o_main_osc_disable(osc));
    sarc_analog_model model (.i_clk_sys(clk), .i_analog_on(aon), .i_dac_code(dac),
        .i_vin(vin), .i_slow(slow), .o_cmp_above(cmp));

    initial
    begin
        forever #5 clk = ~clk;
    end

    // One APB transfer; waits for pready with a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk) n++; while (rdy !== 1'b1 && n < 20);
        rdat = prd;
        err = slv;
        if (n >= 20) fails++;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, ex, rdat)
    endtask : rd_chk

    task automatic wait_done();
        int k;
        k = 0;
        do
        begin
            apb(1'b0, AC, 32'h0);
            k++;
        end while (rdat[6] !== 1'b1 && k < 60);
        if (k >= 60) fails++;
    endtask : wait_done

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // Watchdog well beyond the little over a thousand cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_chk(AC, 32'h40, "ctrl reset");
        // Power still off when start lands, so only done clears
        apb(1'b1, AC, 32'hff);
        rd_chk(AC, 32'h94, "ctrl ones");
        `CHK("osc pin", 1'b1, osc)
        apb(1'b1, AC, 32'h10);
        repeat (3) @(posedge clk);
        `CHK("osc pin off", 1'b0, osc)
        `CHK("analog on", 1'b1, aon)
        $display("test registers done");
        for (int i = 0; i < 5; i++)
        begin
            vin = vtab[i];
            slow = i[0];
            apb(1'b1, AC, 32'h30);
            apb(1'b0, AC, 32'h0);
            `CHK("done cleared", 1'b0, rdat[6])
            wait_done();
            `CHK("dac final", etab[i], dac)
            rd_chk(AR, {24'h0, etab[i]}, "result");
        end
        $display("test conversions done");
        apb(1'b1, AC, 32'h10);
        apb(1'b1, AR, 32'h0);
        rd_chk(AC, 32'h50, "done kept");
        rd_chk(AR, 32'h01, "result ro");
        apb(1'b1, AC, 32'h90);
        wt <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        `CHK("wake", 1'b1, wake)
        apb(1'b1, AC, 32'h10);
        wt <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("irq off", 1'b0, irq)
        $display("test irq done");
        vin = 9'h033;
        apb(1'b1, AC, 32'h30);
        repeat (20) @(posedge clk);
        vin = 9'h0c4;
        apb(1'b1, AC, 32'h30);
        wait_done();
        rd_chk(AR, 32'hc4, "restart");
        repeat (200) @(posedge clk);
        rd_chk(AC, 32'h50, "no rerun");
        $display("test restart done");
        apb(1'b1, AC, 32'h30);
        repeat (10) @(posedge clk);
        stp <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("stop off", 1'b0, aon)
        stp <= 1'b0;
        repeat (150) @(posedge clk);
        rd_chk(AC, 32'h10, "stop abort");
        apb(1'b1, AC, 32'h00);
        repeat (3) @(posedge clk);
        `CHK("power off", 1'b0, aon)
        apb(1'b1, AC, 32'h20);
        repeat (150) @(posedge clk);
        rd_chk(AC, 32'h00, "no conv off");
        apb(1'b0, 12'h348, 32'h0);
        `CHK("slverr", 1'b1, err)
        `CHK("unmapped", 32'h0, rdat)
        $display("test power done");
        give_verdict();
    end
endmodule : sarc_adc_ctrl_tb
